/* src/dpfs_top.sv */
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
// Function selector for pins 1 and 4 with APB register access
module dpfs_top
  import dpfs_pkg::*;
#(
  parameter int DATA_W = DPFS_ADC_W,
  parameter int SAMPLE_CYCLES = DPFS_SAMPLE_CYCLES
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [1:0] conv_ack_in,
  input wire logic [DATA_W-1:0] conv1_data_in,
  input wire logic [DATA_W-1:0] conv4_data_in,
  input wire logic [1:0] id_pin_in,
  output logic [1:0] conv_req_out,
  output logic [1:0] readback_out,
  output logic speed_drive_out,
  output logic dir_drive_out,
  output logic current_mode_out,
  output logic analog_calc_en_out,
  output logic full_duplex_ok_out,
  output logic [1:0] instrument_identity_out,
  output logic [DATA_W-1:0] pin1_value_out,
  output logic [DATA_W-1:0] pin4_value_out
);

  logic duplex_select_q;
  logic [1:0] analog_output_mode_q;
  logic external_identity_select_q;
  logic [2:0] pin1_function_select_q;
  logic [2:0] pin4_function_select_q;
  logic reject_q;
  logic [DPFS_DIV_W-1:0] div_q;
  logic tick_q;

  // APB decode
  wire access_w = psel_in && penable_in;
  wire wr_w = access_w && pwrite_in && pready_out;
  wire hit_ctrl_w = (paddr_in == DPFS_CTRL_OFS);
  wire hit_p1_w = (paddr_in == DPFS_PIN1_SEL_OFS);
  wire hit_p4_w = (paddr_in == DPFS_PIN4_SEL_OFS);
  wire hit_st_w = (paddr_in == DPFS_STATUS_OFS);
  wire hit_v1_w = (paddr_in == DPFS_PIN1_VAL_OFS);
  wire hit_v4_w = (paddr_in == DPFS_PIN4_VAL_OFS);
  wire mapped_w = hit_ctrl_w || hit_p1_w || hit_p4_w || hit_st_w || hit_v1_w || hit_v4_w;

  // Selector write checks
  wire [2:0] sel_wdata_w = pwdata_in[2:0];
  wire sel_range_ok_w = (pwdata_in[31:3] == 29'h0) && (sel_wdata_w <= DPFS_SEL_MAX);
  wire sel_wr_w = wr_w && (hit_p1_w || hit_p4_w);
  wire sel_ok_w = sel_range_ok_w && duplex_select_q;
  wire [1:0] mode_wdata_w = pwdata_in[DPFS_CTRL_MODE_LSB +: 2];
  wire mode_ok_w = (mode_wdata_w <= DPFS_AOM_MAX);
  wire mode_chg_ok_w = mode_ok_w && duplex_select_q;

  // Per-pin decoded functions
  wire [1:0] analog_in_w;
  wire [1:0] readback_w;
  wire [1:0] drive_w;
  wire [1:0] ident_w;
  wire [1:0] sample_en_w;
  wire [1:0] id_bit_w;
  wire [DATA_W-1:0] value_w [1:0];
  wire [2:0] sel_w [1:0];
  wire [DATA_W-1:0] conv_data_w [1:0];
  wire [1:0] conv_req_w;
  wire mode_voltage_w = (analog_output_mode_q == DPFS_AOM_VOLTAGE);
  wire mode_unused_w = (analog_output_mode_q == DPFS_AOM_UNUSED);

  assign sel_w[0] = pin1_function_select_q;
  assign sel_w[1] = pin4_function_select_q;
  assign conv_data_w[0] = conv1_data_in;
  assign conv_data_w[1] = conv4_data_in;

  // Function decode and one channel per pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      assign analog_in_w[gi] = (sel_w[gi] == DPFS_SEL_ANALOG_IN);
      // Read-back only meaningful with a voltage output
      assign readback_w[gi] = (sel_w[gi] == DPFS_SEL_READBACK) && mode_voltage_w;
      assign drive_w[gi] = (sel_w[gi] == DPFS_SEL_ANALOG_OUT) && !mode_unused_w;
      assign ident_w[gi] = (sel_w[gi] == DPFS_SEL_IDENT);
      assign sample_en_w[gi] = analog_in_w[gi] || readback_w[gi];
      dpfs_chan #(
        .DATA_W(DATA_W)
      ) u_chan (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .sample_en_in(sample_en_w[gi]),
        .tick_in(tick_q),
        .conv_ack_in(conv_ack_in[gi]),
        .conv_data_in(conv_data_w[gi]),
        .id_pin_in(id_pin_in[gi]),
        .conv_req_out(conv_req_w[gi]),
        .value_out(value_w[gi]),
        .id_bit_out(id_bit_w[gi])
      );
    end
  endgenerate

  // Derived pin state
  wire all_unused_w = (pin1_function_select_q == DPFS_SEL_UNUSED)
                   && (pin4_function_select_q == DPFS_SEL_UNUSED);
  wire full_ok_w = all_unused_w;
  // Analog output on pin also used as the read-back source
  wire speed_drv_w = drive_w[0] || readback_w[0];
  wire dir_drv_w = drive_w[1] || readback_w[1];
  wire calc_en_w = !(mode_unused_w && all_unused_w);
  wire [1:0] ident_d_w = {ident_w[1] && external_identity_select_q && id_bit_w[1],
                          ident_w[0] && external_identity_select_q && id_bit_w[0]};

  // Status word
  wire [31:0] status_w = {25'h0,
                          reject_q,
                          ident_d_w,
                          full_ok_w,
                          calc_en_w,
                          dir_drv_w,
                          speed_drv_w};
  wire [31:0] ctrl_rd_w = {28'h0, external_identity_select_q, analog_output_mode_q,
                           duplex_select_q};

  // Read data select
  logic [31:0] rd_mux_w;
  always_comb
  begin
    rd_mux_w = 32'h0;
    if (hit_ctrl_w)
      rd_mux_w = ctrl_rd_w;
    else if (hit_p1_w)
      rd_mux_w = {29'h0, pin1_function_select_q};
    else if (hit_p4_w)
      rd_mux_w = {29'h0, pin4_function_select_q};
    else if (hit_st_w)
      rd_mux_w = status_w;
    else if (hit_v1_w)
      rd_mux_w = {{(32-DATA_W){1'b0}}, value_w[0]};
    else if (hit_v4_w)
      rd_mux_w = {{(32-DATA_W){1'b0}}, value_w[1]};
  end

  // APB answer, one wait state
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= access_w && !pready_out;
      if (access_w && !pready_out)
      begin
        prdata_out <= pwrite_in ? 32'h0 : rd_mux_w;
        pslverr_out <= !mapped_w;
      end
      else
      begin
        prdata_out <= 32'h0;
        pslverr_out <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      duplex_select_q <= DPFS_HALF_RST;
      analog_output_mode_q <= DPFS_AOM_RST;
      external_identity_select_q <= DPFS_XID_RST;
    end
    else if (wr_w && hit_ctrl_w)
    begin
      // Full duplex refused while a pin is in use
      duplex_select_q <= pwdata_in[DPFS_CTRL_HALF_BIT] || !all_unused_w;
      if (mode_chg_ok_w)
        analog_output_mode_q <= mode_wdata_w;
      external_identity_select_q <= pwdata_in[DPFS_CTRL_XID_BIT];
    end
  end

  // Pin selectors
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin1_function_select_q <= DPFS_SEL_RST;
      pin4_function_select_q <= DPFS_SEL_RST;
    end
    else if (sel_wr_w && sel_ok_w)
    begin
      if (hit_p1_w)
        pin1_function_select_q <= sel_wdata_w;
      if (hit_p4_w)
        pin4_function_select_q <= sel_wdata_w;
    end
  end

  // Refused write flag, cleared by next accepted selector write or by a control write that is not refused
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      reject_q <= 1'b0;
    else if (sel_wr_w)
      reject_q <= !sel_ok_w;
    else if (wr_w && hit_ctrl_w)
      reject_q <= !mode_chg_ok_w && (mode_wdata_w != analog_output_mode_q);
  end

  // Cyclic sample tick divider
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else if (div_q == DPFS_DIV_W'(SAMPLE_CYCLES - 1))
    begin
      div_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Registered pin-side outputs
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      conv_req_out <= 2'b00;
      readback_out <= 2'b00;
      speed_drive_out <= 1'b0;
      dir_drive_out <= 1'b0;
      current_mode_out <= 1'b0;
      analog_calc_en_out <= 1'b1;
      full_duplex_ok_out <= 1'b1;
      instrument_identity_out <= 2'b00;
      pin1_value_out <= '0;
      pin4_value_out <= '0;
    end
    else
    begin
      conv_req_out <= conv_req_w;
      readback_out <= readback_w;
      speed_drive_out <= speed_drv_w;
      dir_drive_out <= dir_drv_w;
      current_mode_out <= (analog_output_mode_q == DPFS_AOM_CURRENT);
      analog_calc_en_out <= calc_en_w;
      full_duplex_ok_out <= full_ok_w && !duplex_select_q;
      instrument_identity_out <= ident_d_w;
      pin1_value_out <= value_w[0];
      pin4_value_out <= value_w[1];
    end
  end

endmodule

/* src/dpfs_pkg.sv */
package dpfs_pkg;

  // Register byte offsets
  localparam logic [7:0] DPFS_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPFS_PIN1_SEL_OFS = 8'h04;
  localparam logic [7:0] DPFS_PIN4_SEL_OFS = 8'h08;
  localparam logic [7:0] DPFS_STATUS_OFS = 8'h0c;
  localparam logic [7:0] DPFS_PIN1_VAL_OFS = 8'h10;
  localparam logic [7:0] DPFS_PIN4_VAL_OFS = 8'h14;

  // Control field positions
  localparam int DPFS_CTRL_HALF_BIT = 0;
  localparam int DPFS_CTRL_MODE_LSB = 1;
  localparam int DPFS_CTRL_XID_BIT = 3;

  // Status field positions
  localparam int DPFS_ST_SPEED_DRV_BIT = 0;
  localparam int DPFS_ST_DIR_DRV_BIT = 1;
  localparam int DPFS_ST_CALC_BIT = 2;
  localparam int DPFS_ST_FULL_OK_BIT = 3;
  localparam int DPFS_ST_ID_LSB = 4;
  localparam int DPFS_ST_REJ_BIT = 6;

  // Selector encodings
  typedef enum logic [2:0] {
    DPFS_SEL_UNUSED = 3'b000,
    DPFS_SEL_ANALOG_IN = 3'b001,
    DPFS_SEL_READBACK = 3'b010,
    DPFS_SEL_ANALOG_OUT = 3'b011,
    DPFS_SEL_IDENT = 3'b100
  } dpfs_sel_t;
  localparam logic [2:0] DPFS_SEL_MAX = 3'h4;

  // Analog output modes
  typedef enum logic [1:0] {
    DPFS_AOM_VOLTAGE = 2'b00,
    DPFS_AOM_CURRENT = 2'b01,
    DPFS_AOM_UNUSED = 2'b10
  } dpfs_aom_t;
  localparam logic [1:0] DPFS_AOM_MAX = 2'h2;

  // Reset values
  localparam logic [2:0] DPFS_SEL_RST = 3'h0;
  localparam logic [1:0] DPFS_AOM_RST = 2'h0;
  localparam logic DPFS_HALF_RST = 1'b0;
  localparam logic DPFS_XID_RST = 1'b0;

  // Conversion data and full scale
  localparam int DPFS_ADC_W = 16;
  localparam int DPFS_FULL_SCALE_MV = 10000;

  // Cyclic sampling period
  localparam int DPFS_CLK_MHZ = 100;
  localparam int DPFS_SAMPLE_PERIOD_US = 10;
  localparam int DPFS_SAMPLE_CYCLES = DPFS_SAMPLE_PERIOD_US * DPFS_CLK_MHZ;
  localparam int DPFS_DIV_W = 16;

  // Converter handshake states
  typedef enum logic [1:0] {
    DPFS_CV_IDLE = 2'b00,
    DPFS_CV_REQ = 2'b01,
    DPFS_CV_DROP = 2'b10
  } dpfs_cv_state_t;

endpackage

/* src/dpfs_chan.sv */
`timescale 1ns/1ps
// One pin: cyclic converter handshake and identity bit capture
module dpfs_chan
  import dpfs_pkg::*;
#(
  parameter int DATA_W = DPFS_ADC_W
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic sample_en_in,
  input wire logic tick_in,
  input wire logic conv_ack_in,
  input wire logic [DATA_W-1:0] conv_data_in,
  input wire logic id_pin_in,
  output logic conv_req_out,
  output logic [DATA_W-1:0] value_out,
  output logic id_bit_out
);

  logic ack_s1_q;
  logic ack_s2_q;
  logic [DATA_W-1:0] data_s1_q;
  logic [DATA_W-1:0] data_s2_q;
  logic id_s1_q;
  logic id_s2_q;
  logic pend_q;
  dpfs_cv_state_t state_q;
  dpfs_cv_state_t state_d;

  // Two-stage synchronisers for pin-side inputs
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      data_s1_q <= '0;
      data_s2_q <= '0;
      id_s1_q <= 1'b0;
      id_s2_q <= 1'b0;
    end
    else
    begin
      ack_s1_q <= conv_ack_in;
      ack_s2_q <= ack_s1_q;
      data_s1_q <= conv_data_in;
      data_s2_q <= data_s1_q;
      id_s1_q <= id_pin_in;
      id_s2_q <= id_s1_q;
    end
  end

  // Handshake sequencing, four phase
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DPFS_CV_IDLE:
      begin
        if (pend_q && sample_en_in)
          state_d = DPFS_CV_REQ;
      end
      DPFS_CV_REQ:
      begin
        if (ack_s2_q)
          state_d = DPFS_CV_DROP;
      end
      DPFS_CV_DROP:
      begin
        if (!ack_s2_q)
          state_d = DPFS_CV_IDLE;
      end
      default:
        state_d = DPFS_CV_IDLE;
    endcase
  end

  // Sample request pending, value capture
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q <= DPFS_CV_IDLE;
      pend_q <= 1'b0;
      conv_req_out <= 1'b0;
      value_out <= '0;
      id_bit_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // New tick wins over start of conversion
      if (tick_in && sample_en_in)
        pend_q <= 1'b1;
      else if (state_q == DPFS_CV_IDLE && state_d == DPFS_CV_REQ)
        pend_q <= 1'b0;
      else if (!sample_en_in)
        pend_q <= 1'b0;
      conv_req_out <= (state_d == DPFS_CV_REQ);
      if (state_q == DPFS_CV_REQ && ack_s2_q)
        value_out <= data_s2_q;
      id_bit_out <= id_s2_q;
    end
  end

endmodule

/* verification/dpfs_checker.sv */
`timescale 1ns/1ps
// Port-level checks of the pin function selector
module dpfs_checker
  import dpfs_pkg::*;
#(
  parameter int DATA_W = DPFS_ADC_W
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [1:0] conv_ack_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [1:0] conv_req_out,
  input wire logic [1:0] readback_out,
  input wire logic speed_drive_out,
  input wire logic dir_drive_out,
  input wire logic current_mode_out,
  input wire logic analog_calc_en_out,
  input wire logic full_duplex_ok_out,
  input wire logic [1:0] instrument_identity_out,
  input wire logic [DATA_W-1:0] pin1_value_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // Bus answer after exactly one wait state
  a_ready_one_wait: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
    else $error("bus answer not in second access cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out && psel_in)
    else $error("error flag without ready");
  // Pins in use forbid full duplex
  a_busy_no_full: assert property (conv_req_out != 2'h0 || speed_drive_out |-> !full_duplex_ok_out)
    else $error("full duplex allowed while a pin is in use");
  // Analog input on pin 1 turns the speed output off
  a_in_no_speed: assert property (conv_req_out[0] && !readback_out[0] |-> !speed_drive_out)
    else $error("speed output driven during analog input");
  // A request still finishing after a selector change is legal, so only new starts count
  a_in_no_dir: assert property (dir_drive_out && $past(dir_drive_out)
    && !readback_out[1] && !$past(readback_out[1]) |-> !$rose(conv_req_out[1]))
    else $error("conversion started while direction output driven");
  // Read-back only in voltage mode
  a_rb_voltage: assert property (readback_out != 2'h0 |-> !current_mode_out)
    else $error("read-back active in current mode");
  // Request held until acknowledge is seen
  a_req_hold: assert property (conv_req_out[0] && !conv_ack_in[0] |=> conv_req_out[0])
    else $error("request dropped without acknowledge");
  // Value changes only after an acknowledge
  a_value_cause: assert property (!$stable(pin1_value_out) |-> $past(conv_ack_in[0], 2))
    else $error("pin 1 value changed without conversion");
  a_calc_off_idle: assert property (!analog_calc_en_out |-> !speed_drive_out
    && !dir_drive_out && conv_req_out == 2'h0 && instrument_identity_out == 2'h0)
    else $error("activity while analog calculation is off");
endmodule

/* verification/dpfs_conv_model.sv */
`timescale 1ns/1ps
// Converter at the far side: four-phase answer after a set delay
module dpfs_conv_model #(
  parameter int DELAY = 1,
  parameter logic [15:0] VALUE = 16'h1234
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic req_in,
  output logic ack_out,
  output logic [15:0] data_out
);
  int cnt_q;

  // Data only valid while ack is high, inverted otherwise
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ack_out <= 1'b0;
      data_out <= ~VALUE;
      cnt_q <= 0;
    end
    else if (req_in && !ack_out)
    begin
      if (cnt_q == DELAY)
      begin
        ack_out <= 1'b1;
        data_out <= VALUE;
        cnt_q <= 0;
      end
      else
        cnt_q <= cnt_q + 1;
    end
    else if (!req_in && ack_out)
    begin
      ack_out <= 1'b0;
      data_out <= ~VALUE; // Pin released, stale value gone
    end
  end
endmodule

/* verification/dpfs_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the pin function selector
module dpfs_tb_top;
  import dpfs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, spd, dir, cur, calc, fdok;
  logic [1:0] ack, req, rb, ident;
  logic [1:0] id_pin = 2'h0;
  logic [15:0] d1, d4, v1, v4;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  dpfs_top #(.SAMPLE_CYCLES(8)) dpfs_top_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .conv_ack_in(ack), .conv1_data_in(d1), .conv4_data_in(d4), .id_pin_in(id_pin),
    .conv_req_out(req), .readback_out(rb), .speed_drive_out(spd), .dir_drive_out(dir),
    .current_mode_out(cur), .analog_calc_en_out(calc), .full_duplex_ok_out(fdok),
    .instrument_identity_out(ident), .pin1_value_out(v1), .pin4_value_out(v4));
  dpfs_conv_model #(.DELAY(1), .VALUE(16'h1234)) conv1_inst (.clk_in(clk_sys_in),
    .reset_in(reset_in), .req_in(req[0]), .ack_out(ack[0]), .data_out(d1));
  dpfs_conv_model #(.DELAY(6), .VALUE(16'habcd)) conv4_inst (.clk_in(clk_sys_in),
    .reset_in(reset_in), .req_in(req[1]), .ack_out(ack[1]), .data_out(d4));

  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n == 20)
    begin
      bad_count++;
      $display("FAIL %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
  endtask

  task automatic t_reset();
    rd(DPFS_CTRL_OFS, 32'hf, 32'h0);
    rd(DPFS_PIN1_SEL_OFS, 32'h7, 32'h0);
    rd(DPFS_PIN4_SEL_OFS, 32'h7, 32'h0);
    chk({30'h0, fdok, calc}, 32'h3);
    $display("reset values done");
  endtask

  task automatic t_gate();
    wr(DPFS_PIN1_SEL_OFS, 32'h1);
    rd(DPFS_PIN1_SEL_OFS, 32'h7, 32'h0);
    rd(DPFS_STATUS_OFS, 32'h40, 32'h40);
    wr(DPFS_CTRL_OFS, 32'h2);
    rd(DPFS_CTRL_OFS, 32'hf, 32'h0);
    $display("duplex gate done");
  endtask

  task automatic t_range();
    logic [31:0] r;
    logic e;
    wr(DPFS_CTRL_OFS, 32'h1);
    for (int v = 0; v < 5; v++)
    begin
      wr(DPFS_PIN4_SEL_OFS, 32'(v));
      rd(DPFS_PIN4_SEL_OFS, 32'h7, 32'(v));
    end
    wr(DPFS_PIN4_SEL_OFS, 32'h5);
    rd(DPFS_PIN4_SEL_OFS, 32'h7, 32'h4);
    rd(DPFS_STATUS_OFS, 32'h40, 32'h40);
    wr(DPFS_PIN4_SEL_OFS, 32'h8);
    rd(DPFS_PIN4_SEL_OFS, 32'h7, 32'h4);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("selector range done");
  endtask

  task automatic t_convert();
    int n;
    wr(DPFS_PIN1_SEL_OFS, 32'h1);
    wr(DPFS_PIN4_SEL_OFS, 32'h1);
    n = 0;
    while ((v1 !== 16'h1234 || v4 !== 16'habcd) && n < 200)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    chk({v1, v4}, 32'h1234abcd);
    chk({29'h0, spd, dir, fdok}, 32'h0);
    rd(DPFS_PIN1_VAL_OFS, 32'hffff, 32'h1234);
    rd(DPFS_PIN4_VAL_OFS, 32'hffff, 32'habcd);
    $display("conversion done");
  endtask

  task automatic t_readback();
    wr(DPFS_PIN1_SEL_OFS, 32'h2);
    wr(DPFS_PIN4_SEL_OFS, 32'h2);
    chk({30'h0, rb}, 32'h3);
    wr(DPFS_CTRL_OFS, 32'h3);
    chk({29'h0, rb, cur}, 32'h1);
    wr(DPFS_CTRL_OFS, 32'h7);
    rd(DPFS_CTRL_OFS, 32'hf, 32'h3);
    $display("read-back done");
  endtask

  task automatic t_drive();
    wr(DPFS_PIN1_SEL_OFS, 32'h3);
    wr(DPFS_PIN4_SEL_OFS, 32'h3);
    chk({30'h0, spd, dir}, 32'h3);
    rd(DPFS_STATUS_OFS, 32'h3, 32'h3);
    $display("analog drive done");
  endtask

  task automatic t_ident();
    wr(DPFS_CTRL_OFS, 32'h9);
    id_pin <= 2'h2;
    wr(DPFS_PIN1_SEL_OFS, 32'h4);
    wr(DPFS_PIN4_SEL_OFS, 32'h4);
    chk({30'h0, ident}, 32'h2);
    id_pin <= 2'h1;
    repeat (6) @(posedge clk_sys_in);
    chk({30'h0, ident}, 32'h1);
    $display("identity done");
  endtask

  task automatic t_calc_off();
    wr(DPFS_PIN1_SEL_OFS, 32'h0);
    wr(DPFS_PIN4_SEL_OFS, 32'h0);
    wr(DPFS_CTRL_OFS, 32'h5);
    chk({31'h0, calc}, 32'h0);
    wr(DPFS_CTRL_OFS, 32'h4);
    chk({31'h0, fdok}, 32'h1);
    $display("calculation off done");
  endtask

  // Cut a hang short
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("FAIL %0t: run timed out", $time);
      test_done();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_gate();
    t_range();
    t_convert();
    t_readback();
    t_drive();
    t_ident();
    t_calc_off();
    test_done();
  end
endmodule

bind dpfs_top dpfs_checker #(.DATA_W(DATA_W)) dpfs_checker_inst (.clk_sys_in(clk_sys_in),
  .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in), .conv_ack_in(conv_ack_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .conv_req_out(conv_req_out),
  .readback_out(readback_out), .speed_drive_out(speed_drive_out),
  .dir_drive_out(dir_drive_out), .current_mode_out(current_mode_out),
  .analog_calc_en_out(analog_calc_en_out), .full_duplex_ok_out(full_duplex_ok_out),
  .instrument_identity_out(instrument_identity_out), .pin1_value_out(pin1_value_out));
